// ---- hdl/io_expander_ctl.sv ----
// Controller end: AXI4-Lite register slave driving single-byte link transfers
//
// The AXI4-Lite slave port was chosen for this implementation.
module io_expander_ctl (
  input wire logic aclk,
  input wire logic aresetn,
  io_expander_link_if.host link,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  typedef enum logic [2:0] {H_IDLE, H_START, H_BYTE, H_RSTART, H_STOP} eng_t;

  function automatic eng_t step_kind(input logic rd, input logic [2:0] st);
    if (st == '0) step_kind = H_START;
    else if (st == (rd ? io_expander_pkg::STEP_RD_LAST : io_expander_pkg::STEP_WR_LAST)) step_kind = H_STOP;
    else if (rd && st == 3'h3) step_kind = H_RSTART;
    else step_kind = H_BYTE;
  endfunction

  // Returns {scl high, sda high} for one quarter of an element
  function automatic logic [1:0] wave(input eng_t e, input logic [1:0] q, input logic [3:0] b, input logic d);
    logic hi;
    hi = (q == 2'h1) || (q == io_expander_pkg::Q_SAMPLE);
    unique case (e)
      H_IDLE: wave = 2'b11;
      H_START: wave = {1'b1, q == 2'h0};
      H_RSTART: wave = {hi, q < io_expander_pkg::Q_SAMPLE};
      H_STOP: wave = {q != 2'h0, q >= io_expander_pkg::Q_SAMPLE};
      H_BYTE: wave = {hi, (b == io_expander_pkg::BYTE_DONE) ? 1'b1 : d};
    endcase
  endfunction

  // ****************
  // Register slave
  // ****************
  logic aw_got, next_aw_got, w_got, next_w_got;
  logic [7:0] wa, next_wa, ctrl, next_ctrl, cmd, next_cmd, wbyte, next_wbyte;
  logic wen, next_wen;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic start_req;
  logic [7:0] wdata_q, next_wdata_q;
  eng_t eng;
  logic nack;
  logic [7:0] rx;

  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_wa = wa;
    next_wen = wen;
    next_ctrl = ctrl;
    next_cmd = cmd;
    next_wbyte = wbyte;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    start_req = 1'b0;
    if (awvalid && awready) begin
      next_aw_got = 1'b1;
      next_wa = awaddr;
    end
    if (wvalid && wready) begin
      next_w_got = 1'b1;
      next_wen = wstrb[0];
    end
    if (aw_got && w_got && !bvalid) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = io_expander_pkg::RESP_OKAY;
      unique case (wa)
        io_expander_pkg::OFS_CTRL: begin
          if (wen && eng == H_IDLE) begin
            next_ctrl = wdata_q;
            start_req = 1'b1;
          end
        end
        io_expander_pkg::OFS_CMD: if (wen) next_cmd = wdata_q;
        io_expander_pkg::OFS_WDATA: if (wen) next_wbyte = wdata_q;
        io_expander_pkg::OFS_RDATA, io_expander_pkg::OFS_STATUS: begin
        end
        default: next_bresp = io_expander_pkg::RESP_SLVERR;
      endcase
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = io_expander_pkg::RESP_OKAY;
      unique case (araddr)
        io_expander_pkg::OFS_CTRL: next_rdata = {24'h000000, ctrl};
        io_expander_pkg::OFS_CMD: next_rdata = {24'h000000, cmd};
        io_expander_pkg::OFS_WDATA: next_rdata = {24'h000000, wbyte};
        io_expander_pkg::OFS_RDATA: next_rdata = {24'h000000, rx};
        io_expander_pkg::OFS_STATUS: next_rdata = {30'h0, nack, eng != H_IDLE};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = io_expander_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;
    next_arready = !next_rvalid;
  end

  assign next_wdata_q = (wvalid && wready) ? wdata[7:0] : wdata_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wa <= '0;
      wen <= 1'b0;
      wdata_q <= '0;
      ctrl <= '0;
      cmd <= '0;
      wbyte <= '0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= io_expander_pkg::RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= io_expander_pkg::RESP_OKAY;
      rdata <= '0;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      wa <= next_wa;
      wen <= next_wen;
      wdata_q <= next_wdata_q;
      ctrl <= next_ctrl;
      cmd <= next_cmd;
      wbyte <= next_wbyte;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // ****************
  // Link engine
  // ****************
  eng_t next_eng;
  logic [1:0] q, next_q;
  logic [3:0] tick, next_tick, bitn, next_bitn;
  logic [2:0] step, next_step;
  logic [7:0] sh, next_sh, next_rx;
  logic next_nack, rd, rd_byte, next_rd_byte, qend;
  logic s1, s2, s3, sda_f, next_sda_f;
  logic scl_oe, sda_oe;
  logic [1:0] lines;

  always_comb begin
    rd = ctrl[io_expander_pkg::CTRL_RW_BIT];
    rd_byte = rd && step == io_expander_pkg::STEP_RD_BYTE;
    next_sda_f = (s2 == s3) ? s3 : sda_f;
    next_eng = eng;
    next_q = q;
    next_tick = tick;
    next_bitn = bitn;
    next_step = step;
    next_sh = sh;
    next_nack = nack;
    next_rx = rx;
    qend = tick == io_expander_pkg::QUARTER_LAST;
    if (eng == H_IDLE) begin
      if (start_req) begin
        next_eng = H_START; // R11 R12
        next_step = '0;
        next_q = '0;
        next_tick = '0;
        next_nack = 1'b0;
      end
    end else begin
      next_tick = qend ? 4'h0 : tick + 4'h1;
      if (qend) begin
        next_q = q + 2'h1;
        if (q == io_expander_pkg::Q_SAMPLE && eng == H_BYTE) begin
          if (bitn == io_expander_pkg::BYTE_DONE) begin
            if (!rd_byte && sda_f) next_nack = 1'b1;
          end else if (rd_byte) begin
            next_rx = {rx[6:0], sda_f};
          end
        end
        if (q == io_expander_pkg::Q_LAST) begin
          if (eng == H_BYTE && bitn != io_expander_pkg::BYTE_DONE) begin
            next_bitn = bitn + 4'h1;
            next_sh = {sh[6:0], 1'b1};
          end else if (eng == H_STOP) begin
            next_eng = H_IDLE; // R16
          end else begin
            // A refused byte ends the frame at once
            next_step = nack ? (rd ? io_expander_pkg::STEP_RD_LAST : io_expander_pkg::STEP_WR_LAST) : step + 3'h1; // R16
            next_eng = step_kind(rd, next_step); // R05 R12
            next_bitn = '0;
            unique case (next_step)
              3'h1: next_sh = {ctrl[6:0], 1'b0}; // R02
              3'h2: next_sh = cmd; // R05
              3'h3: next_sh = wbyte;
              3'h4: next_sh = {ctrl[6:0], 1'b1}; // R02 R12
              default: next_sh = 8'hFF; // R15
            endcase
          end
        end
      end
    end
    next_rd_byte = rd && next_step == io_expander_pkg::STEP_RD_BYTE;
    // Single read byte: the acknowledge slot stays released
    lines = wave(next_eng, next_q, next_bitn, next_rd_byte | next_sh[7]); // R15
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      sda_f <= 1'b1;
      eng <= H_IDLE;
      q <= '0;
      tick <= '0;
      bitn <= '0;
      step <= '0;
      sh <= '1;
      nack <= 1'b0;
      rx <= '0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      s1 <= link.sda;
      s2 <= s1;
      s3 <= s2;
      sda_f <= next_sda_f;
      eng <= next_eng;
      q <= next_q;
      tick <= next_tick;
      bitn <= next_bitn;
      step <= next_step;
      sh <= next_sh;
      nack <= next_nack;
      rx <= next_rx;
      scl_oe <= ~lines[1];
      sda_oe <= ~lines[0];
    end
  end

  assign link.host_scl_oe = scl_oe;
  assign link.host_sda_oe = sda_oe;
  assign link.host_scl_o = 1'b0;
  assign link.host_sda_o = 1'b0;

endmodule

// ---- hdl/io_expander_ctl_fix.sv ----
// Holds no logic: each end of the link lives in its own file

// ---- hdl/io_expander_dev.sv ----
// Expander end: serial slave, pointer, four 8-bit port registers and pin drive
// Notes on behaviour
// R01 - Answer only address fixed bits plus straps
// R02 - Last address bit one means read
// R03 - First write byte after address is pointer
// R04 - Pointer low two bits pick register
// R05 - Reads never change the pointer
// R06 - Pointer persists until next command byte
// R07 - Input register shows pins, ignores writes
// R08 - Latch drives output pins, reads latch
// R09 - Invert bits flip reported input level
// R10 - Direction one input, zero output
// R11 - Write: address, command, any data bytes
// R12 - Master reads via command, restart, read address
// R13 - Restart keeps current register selection
// R14 - Input captured at acknowledge clock rise
// R15 - Send bytes until master withholds acknowledge
// R16 - Stop releases bus, await start
// R17 - Acknowledge every written byte, two selector bits
module io_expander_dev (
  input wire logic aclk,
  input wire logic aresetn,
  io_expander_link_if.device link,
  input wire logic [7:0] port_pin_i,
  output logic [7:0] port_pin_o,
  output logic [7:0] port_pin_oe,
  input wire logic [2:0] addr_strap
);

  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ADDR_ACK, D_RX, D_RX_ACK, D_TX, D_TX_ACK, D_WAIT} dev_state_t;

  // ****************
  // Input synchroniser
  // ****************
  logic [io_expander_pkg::SYNC_W-1:0] s1, s2, s3, filt;
  logic [io_expander_pkg::SYNC_W-1:0] next_s1, next_s2, next_s3, next_filt;

  always_comb begin
    next_s1 = {addr_strap, port_pin_i, link.sda, link.scl};
    next_s2 = s1;
    next_s3 = s2;
    // A change counts once the last two stages agree
    next_filt = (s3 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      filt <= '1;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      filt <= next_filt;
    end
  end

  logic scl_rise, scl_fall, start_seen, stop_seen, sda_now;
  logic [7:0] pins_now;
  logic [2:0] strap_now;

  always_comb begin
    scl_rise = next_filt[0] & ~filt[0];
    scl_fall = ~next_filt[0] & filt[0];
    start_seen = filt[0] & next_filt[0] & filt[1] & ~next_filt[1];
    stop_seen = filt[0] & next_filt[0] & ~filt[1] & next_filt[1];
    sda_now = next_filt[1];
    pins_now = filt[9:2];
    strap_now = filt[12:10];
  end

  // ****************
  // Protocol and registers
  // ****************
  dev_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] shift, next_shift;
  logic [7:0] tx, next_tx;
  logic rw, next_rw;
  logic got_cmd, next_got_cmd;
  logic [7:0] cmd, next_cmd;
  logic [7:0] input_levels, next_input_levels;
  logic [7:0] output_latch, next_output_latch;
  logic [7:0] polarity_invert, next_polarity_invert;
  logic [7:0] direction_config, next_direction_config;
  logic sda_oe, next_sda_oe;
  logic [7:0] next_pin_oe;

  function automatic logic [7:0] read_reg(input logic [1:0] sel, input logic [7:0] inp, input logic [7:0] lat,
                                          input logic [7:0] inv, input logic [7:0] dir);
    unique case (sel)
      io_expander_pkg::SEL_INPUT: read_reg = inp;
      io_expander_pkg::SEL_LATCH: read_reg = lat;
      io_expander_pkg::SEL_INVERT: read_reg = inv;
      io_expander_pkg::SEL_DIR: read_reg = dir;
    endcase
  endfunction

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_tx = tx;
    next_rw = rw;
    next_got_cmd = got_cmd;
    next_cmd = cmd;
    next_input_levels = input_levels;
    next_output_latch = output_latch;
    next_polarity_invert = polarity_invert;
    next_direction_config = direction_config;
    next_sda_oe = sda_oe;
    if (start_seen) begin
      // Start and restart alike; the pointer is left as it stands
      next_state = D_ADDR; // R13
      next_cnt = '0;
      next_got_cmd = 1'b0;
      next_sda_oe = 1'b0;
    end else if (stop_seen) begin
      next_state = D_IDLE; // R16
      next_sda_oe = 1'b0; // R16
    end else begin
      unique case (state)
        D_IDLE, D_WAIT: begin
        end
        D_ADDR: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_now};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == io_expander_pkg::BYTE_DONE) begin
            if (shift[7:1] == {io_expander_pkg::ADDR_FIXED, strap_now}) begin // R01
              next_rw = shift[0]; // R02
              next_sda_oe = 1'b1;
              next_state = D_ADDR_ACK;
            end else begin
              next_state = D_WAIT; // R01
            end
          end
        end
        D_ADDR_ACK: begin
          if (scl_rise && rw) begin
            next_input_levels = pins_now ^ polarity_invert; // R14 R07 R09
          end
          if (scl_fall) begin
            next_cnt = '0;
            if (rw) begin
              // Pointer is only read here, never loaded
              next_tx = read_reg(cmd[1:0], input_levels, output_latch, polarity_invert, direction_config); // R05 R06
              next_sda_oe = ~next_tx[7];
              next_state = D_TX; // R02
            end else begin
              next_sda_oe = 1'b0;
              next_state = D_RX;
            end
          end
        end
        D_RX: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_now};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == io_expander_pkg::BYTE_DONE) begin
            if (!got_cmd) begin
              next_cmd = shift; // R03
              next_got_cmd = 1'b1;
            end else begin
              // Data bytes go on landing in the same register
              unique case (cmd[1:0]) // R04 R17 R11
                io_expander_pkg::SEL_INPUT: begin
                end // R07
                io_expander_pkg::SEL_LATCH: next_output_latch = shift; // R08
                io_expander_pkg::SEL_INVERT: next_polarity_invert = shift; // R09
                io_expander_pkg::SEL_DIR: next_direction_config = shift; // R10
              endcase
            end
            next_sda_oe = 1'b1; // R17
            next_state = D_RX_ACK;
          end
        end
        D_RX_ACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_cnt = '0;
            next_state = D_RX; // R11
          end
        end
        D_TX: begin
          if (scl_fall) begin
            if (cnt == io_expander_pkg::BIT_LAST) begin
              next_sda_oe = 1'b0;
              next_state = D_TX_ACK;
            end else begin
              next_sda_oe = ~tx[6];
              next_tx = {tx[6:0], 1'b1};
              next_cnt = cnt + 4'h1;
            end
          end
        end
        D_TX_ACK: begin
          if (scl_rise) begin
            next_input_levels = pins_now ^ polarity_invert; // R14
            if (sda_now) begin
              next_state = D_WAIT; // R15
            end
          end else if (scl_fall) begin
            next_tx = read_reg(cmd[1:0], input_levels, output_latch, polarity_invert, direction_config); // R15 R06
            next_sda_oe = ~next_tx[7];
            next_cnt = '0;
            next_state = D_TX;
          end
        end
      endcase
    end
    next_pin_oe = ~next_direction_config; // R10
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= D_IDLE;
      cnt <= '0;
      shift <= '0;
      tx <= '1;
      rw <= 1'b0;
      got_cmd <= 1'b0;
      cmd <= io_expander_pkg::CMD_RST;
      input_levels <= io_expander_pkg::INPUT_RST;
      output_latch <= io_expander_pkg::LATCH_RST;
      polarity_invert <= io_expander_pkg::INVERT_RST;
      direction_config <= io_expander_pkg::DIR_RST;
      sda_oe <= 1'b0;
      port_pin_oe <= ~io_expander_pkg::DIR_RST;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      tx <= next_tx;
      rw <= next_rw;
      got_cmd <= next_got_cmd;
      cmd <= next_cmd;
      input_levels <= next_input_levels;
      output_latch <= next_output_latch;
      polarity_invert <= next_polarity_invert;
      direction_config <= next_direction_config;
      sda_oe <= next_sda_oe;
      port_pin_oe <= next_pin_oe;
    end
  end

  // Latch drives every pin, the enable decides which ones see it
  assign port_pin_o = output_latch; // R08
  assign link.dev_sda_oe = sda_oe;
  assign link.dev_sda_o = 1'b0;

endmodule

// ---- hdl/io_expander_link_if.sv ----
// Two-wire open-drain link between the bus controller and the expander
interface io_expander_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-ups
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);

  modport host (output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe, input scl, input sda);
  modport device (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface

// ---- hdl/io_expander_pkg.sv ----
// Shared constants for the I/O expander link, its register front end and its bus controller
package io_expander_pkg;

  // ****************
  // Timing
  // ****************
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 1600;
  localparam int QUARTER_CYC = (SCL_PERIOD_NS / (4 * CLK_PERIOD_NS)) < 1 ? 1 : SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [3:0] QUARTER_LAST = 4'(QUARTER_CYC - 1);

  // ****************
  // Link framing
  // ****************
  localparam logic [3:0] ADDR_FIXED = 4'h7;
  localparam logic [3:0] BYTE_DONE = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam int SYNC_W = 13;

  // ****************
  // Expander registers
  // ****************
  localparam logic [1:0] SEL_INPUT = 2'h0;
  localparam logic [1:0] SEL_LATCH = 2'h1;
  localparam logic [1:0] SEL_INVERT = 2'h2;
  localparam logic [1:0] SEL_DIR = 2'h3;
  localparam logic [7:0] INPUT_RST = 8'h00;
  localparam logic [7:0] LATCH_RST = 8'hFF;
  localparam logic [7:0] INVERT_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] CMD_RST = 8'h00;

  // ****************
  // Controller registers
  // ****************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam int CTRL_RW_BIT = 7;
  localparam logic [2:0] STEP_WR_LAST = 3'h4;
  localparam logic [2:0] STEP_RD_LAST = 3'h6;
  localparam logic [2:0] STEP_RD_BYTE = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- test/i2c_io_expander_registers_tb_top.sv ----
// Bench joining the controller and the expander over the link
module i2c_io_expander_registers_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] DEV = 7'h3D;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, pin_ext, port_pin_o, port_pin_oe, pins;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [2:0] addr_strap;
  int err_total, checks_done;
  io_expander_link_if link();
  // Pin level: driven value where enabled, outside level elsewhere
  assign pins = (port_pin_oe & port_pin_o) | (~port_pin_oe & pin_ext);
  always #50 aclk = ~aclk;
  io_expander_dev i_io_expander_dev (.aclk, .aresetn, .link(link.device), .port_pin_i(pins), .port_pin_o,
    .port_pin_oe, .addr_strap);
  io_expander_ctl i_io_expander_ctl (.aclk, .aresetn, .link(link.host), .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready);
  io_expander_link_sva i_io_expander_link_sva (.aclk, .aresetn, .host_sda_oe(link.host_sda_oe),
    .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
  // ****************
  // Helpers
  // ****************
  task automatic cmp(input logic [31:0] e, input logic [31:0] a);
    checks_done++;
    if (a !== e) begin
      err_total++;
      $display("mismatch at %0t: expected %h got %h", $time, e, a);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] e, input logic [1:0] a);
    cmp({30'h0, e}, {30'h0, a});
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic frame(input logic [6:0] ad, input logic rw, input logic [7:0] c, input logic [7:0] d,
    output logic [31:0] st, output logic [31:0] q);
    logic [1:0] r;
    axi_wr(io_expander_pkg::OFS_CMD, c, r);
    axi_wr(io_expander_pkg::OFS_WDATA, d, r);
    axi_wr(io_expander_pkg::OFS_CTRL, {rw, ad}, r);
    do axi_rd(io_expander_pkg::OFS_STATUS, st, r); while (st[0] !== 1'b0);
    axi_rd(io_expander_pkg::OFS_RDATA, q, r);
  endtask
  task automatic lk_wr(input logic [7:0] c, input logic [7:0] d);
    logic [31:0] st, q;
    frame(DEV, 1'b0, c, d, st, q);
    cmp(32'h0, {31'h0, st[1]});
  endtask
  task automatic lk_rd(input logic [7:0] c, input logic [7:0] e);
    logic [31:0] st, q;
    frame(DEV, 1'b1, c, 8'h00, st, q);
    cmp({24'h0, e}, q);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    cmp(32'hFF, {24'h0, port_pin_o});
    cmp(32'h00, {24'h0, port_pin_oe});
    lk_rd(8'h00, 8'h00);
    lk_rd(8'h01, 8'hFF);
    lk_rd(8'h02, 8'h00);
    lk_rd(8'h03, 8'hFF);
  endtask
  task automatic t_ports();
    lk_wr(8'h03, 8'hF0);
    cmp(32'h0F, {24'h0, port_pin_oe});
    lk_wr(8'h01, 8'hA5);
    cmp(32'hA5, {24'h0, port_pin_o});
    pin_ext <= 8'h3C;
    lk_rd(8'h01, 8'hA5);
    lk_rd(8'h00, 8'h35);
  endtask
  task automatic t_invert();
    lk_wr(8'h02, 8'h30);
    lk_rd(8'h00, 8'h05);
    pin_ext <= 8'hC0;
    lk_rd(8'h00, 8'hF5);
    lk_wr(8'h00, 8'h55);
    lk_rd(8'h02, 8'h30);
    cmp(32'hA5, {24'h0, port_pin_o});
    cmp(32'h0F, {24'h0, port_pin_oe});
  endtask
  task automatic t_addr();
    logic [31:0] st, q;
    frame(7'h38, 1'b0, 8'h01, 8'h00, st, q);
    cmp(32'h1, {31'h0, st[1]});
    cmp(32'hA5, {24'h0, port_pin_o});
    lk_wr(8'hFD, 8'h5A);
    cmp(32'h5A, {24'h0, port_pin_o});
  endtask
  task automatic t_bus();
    logic [31:0] q;
    logic [1:0] r;
    axi_rd(8'h20, q, r);
    cmp_resp(io_expander_pkg::RESP_SLVERR, r);
    cmp(32'h0, q);
    axi_wr(8'h20, 8'h00, r);
    cmp_resp(io_expander_pkg::RESP_SLVERR, r);
    // A write with its low byte lane off is answered but changes nothing
    wstrb <= 4'h0;
    axi_wr(io_expander_pkg::OFS_CMD, 8'h77, r);
    cmp_resp(io_expander_pkg::RESP_OKAY, r);
    wstrb <= 4'hF;
    axi_rd(io_expander_pkg::OFS_CMD, q, r);
    cmp(32'hFD, q);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // About fifteen frames of under a thousand cycles each
  initial begin
    #3000000;
    err_total++;
    summarize();
  end
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    addr_strap = 3'h5;
    pin_ext = 8'h00;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_ports();
    t_invert();
    t_addr();
    t_bus();
    summarize();
  end
endmodule

// ---- test/io_expander_link_sva.sv ----
// Link wire checker for the expander and its controller
module io_expander_link_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************
  // Frame tracking
  // ****************
  logic scl_q, sda_q, act, seen, rd, rise, strt, stp, ack, next_act, next_seen, next_rd;
  logic [3:0] bitn, next_bitn;
  logic [7:0] sh, next_sh;
  assign rise = scl & ~scl_q;
  assign strt = scl & scl_q & sda_q & ~sda;
  assign stp = scl & scl_q & ~sda_q & sda;
  assign ack = rise & act & (bitn == 4'h8);
  always_comb begin
    next_act = (act | strt) & ~stp;
    next_seen = ~strt & (seen | ack);
    next_rd = strt ? 1'b0 : (ack && !seen) ? sh[0] : rd;
    next_bitn = strt ? 4'h0 : !rise ? bitn : (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
    next_sh = (rise && bitn != 4'h8) ? {sh[6:0], sda} : sh;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {scl_q, sda_q, act, seen, rd, bitn, sh} <= {2'h3, 15'h0};
    end else begin
      {scl_q, sda_q, act, seen, rd, bitn, sh} <= {scl, sda, next_act, next_seen, next_rd, next_bitn, next_sh};
    end
  end
  // ****************
  // Properties
  // ****************
  property p_addr_ack; ack && !seen && !sda |-> sh[7:4] == io_expander_pkg::ADDR_FIXED; endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("foreign address acknowledged");
  property p_rx_quiet; rise && act && bitn != 4'h8 && !(seen && rd) |-> !dev_sda_oe; endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("device drives data while receiving");
  property p_wr_ack; ack && seen && !rd |-> !sda; endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("written byte not acknowledged");
  property p_ack_release; $fell(scl) && act && dev_sda_oe && !rd |-> ##[1:8] !dev_sda_oe; endproperty
  a_ack_release: assert property (p_ack_release) else $error("acknowledge not released");
  property p_dev_steady; scl && scl_q |-> $stable(dev_sda_oe); endproperty
  a_dev_steady: assert property (p_dev_steady) else $error("device data moved while clock high");
  property p_rd_release; ack && seen && rd |-> !dev_sda_oe && !host_sda_oe && sda; endproperty
  a_rd_release: assert property (p_rd_release) else $error("last read byte slot not free");
  property p_stop_free; stp |=> !dev_sda_oe [*8]; endproperty
  a_stop_free: assert property (p_stop_free) else $error("device drives after stop");
  property p_scl_high; rise |-> scl [*8]; endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");
endmodule
